// ---- src/pfd_pkg.sv ----
// Constants and types for the power-fail deceleration controller
package pfd_pkg;
    localparam int CLK_PERIOD_PS = 4000;
    localparam int TICK_NS = 1000;
    localparam int TICK_CYC = (TICK_NS * 1000) / CLK_PERIOD_PS;
    localparam logic [1:0] MODE_COAST = 2'h0;
    localparam logic [1:0] MODE_STOP = 2'h1;
    localparam logic [1:0] MODE_CONT = 2'h2;
    localparam logic [15:0] RESTART_OFF = 16'h270f;
    localparam logic [7:0] CODE_POS = 8'h2e;
    localparam logic [7:0] CODE_NEG = 8'h92;
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_RESTART = 8'h04;
    localparam logic [7:0] REG_SETFREQ = 8'h08;
    localparam logic [7:0] REG_STEPS = 8'h0c;
    localparam logic [7:0] REG_TERM = 8'h10;
    localparam logic [7:0] REG_STATUS = 8'h14;
    localparam logic [7:0] REG_IRQ_STAT = 8'h18;
    localparam logic [7:0] REG_IRQ_CLR = 8'h1c;
    localparam logic [7:0] REG_IRQ_EN = 8'h20;
    localparam logic [15:0] SETFREQ_RST = 16'h0000;
    localparam logic [23:0] STEPS_RST = 24'h01_0101;
    localparam int ACC_LSB = 0;
    localparam int DEC_LSB = 8;
    localparam int PFS_LSB = 16;
    localparam int TERMC_LSB = 8;
    localparam int ST_STATE_LSB = 16;
    localparam int ST_FLAG_BIT = 19;
    localparam int ST_REV_BIT = 20;
    localparam int IRQ_W = 4;
    localparam int EV_DECEL = 0;
    localparam int EV_PFSTOP = 1;
    localparam int EV_RESTORE = 2;
    localparam int EV_COAST = 3;
    typedef enum logic [2:0] {
        ST_STOP,
        ST_RUN,
        ST_PF_DECEL,
        ST_PF_STOP,
        ST_COAST
    } pfd_state_t;
endpackage

// ---- src/pfd_ramp.sv ----
// Output frequency ramp toward a target with a fixed step per tick
`timescale 1ns/1ps
`default_nettype none
module pfd_ramp #(
    parameter int FREQ_W = 16
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic tick_i,
    input wire logic zero_i,
    input wire logic [FREQ_W-1:0] target_i,
    input wire logic [7:0] step_i,
    output logic [FREQ_W-1:0] freq_o
);
    logic [FREQ_W-1:0] ext;
    logic [FREQ_W:0] up;
    logic [FREQ_W-1:0] gap;

    // Step widened, sum and distance to target
    always_comb begin
        ext = FREQ_W'(step_i);
        up = {1'b0, freq_o} + {1'b0, ext};
        gap = freq_o - target_i;
    end

    // Move one step per tick, never past the target
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            freq_o <= '0;
        end else if (ce_i) begin
            if (zero_i) begin
                freq_o <= '0;
            end else if (tick_i) begin
                if (freq_o < target_i) begin
                    if (up > {1'b0, target_i}) begin
                        freq_o <= target_i;
                    end else begin
                        freq_o <= up[FREQ_W-1:0];
                    end
                end else if (freq_o > target_i) begin
                    if (gap < ext) begin
                        freq_o <= target_i;
                    end else begin
                        freq_o <= freq_o - ext;
                    end
                end
            end
        end
    end
endmodule
`default_nettype wire

// ---- src/pfd_ctrl.sv ----
// Power-fail deceleration sequencer with Wishbone registers
`timescale 1ns/1ps
`default_nettype none
module pfd_ctrl #(
    parameter int FREQ_W = 16,
    parameter int TICK_DIV = pfd_pkg::TICK_CYC
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic undervoltage_i,
    input wire logic power_loss_i,
    input wire logic forward_start_cmd_i,
    input wire logic reverse_start_cmd_i,
    input wire logic tripped_i,
    output logic output_shutoff_o,
    output logic [FREQ_W-1:0] freq_o,
    output logic reverse_o,
    output logic power_fail_decel_flag_o,
    output logic term_a_o,
    output logic term_c_o,
    output logic irq_o
);
    generate
        if (FREQ_W < 8 || FREQ_W > 16) begin : g_bad_w
            $error("FREQ_W must lie in 8..16");
        end
        if (TICK_DIV < 1 || TICK_DIV > 65535) begin : g_bad_div
            $error("TICK_DIV must lie in 1..65535");
        end
    endgenerate

    pfd_pkg::pfd_state_t state;
    pfd_pkg::pfd_state_t next_state;
    logic [1:0] stop_select;
    logic [15:0] restart_set;
    logic [FREQ_W-1:0] set_freq;
    logic [23:0] steps;
    logic [7:0] term_sel_a;
    logic [7:0] term_sel_c;
    logic [pfd_pkg::IRQ_W-1:0] irq_stat;
    logic [pfd_pkg::IRQ_W-1:0] irq_en;
    logic [pfd_pkg::IRQ_W-1:0] irq_clr;
    logic [pfd_pkg::IRQ_W-1:0] events;
    logic [pfd_pkg::IRQ_W-1:0] next_irq_stat;
    logic fail_q;
    logic fail_d;
    logic start_lock;
    logic [15:0] tick_cnt;
    logic tick;
    logic cmd;
    logic auto_restart;
    logic next_flag;
    logic wr;
    logic rd;
    logic [31:0] wmask;
    logic [31:0] status_word;
    logic [FREQ_W-1:0] ramp_target;
    logic [7:0] ramp_step;
    logic ramp_zero;

    // Bus strobes and byte-lane mask
    always_comb begin
        wr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && ce_i;
        rd = wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o && ce_i;
        wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                 {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    end

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] dat,
                                          input logic [31:0] m);
        merge = (old & ~m) | (dat & m);
    endfunction

    // Combined start command and auto restart selection
    always_comb begin
        cmd = forward_start_cmd_i || reverse_start_cmd_i;
        auto_restart = (restart_set != pfd_pkg::RESTART_OFF);
    end

    // Supply loss sampled as one event
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            fail_q <= 1'b0;
            fail_d <= 1'b0;
        end else if (ce_i) begin
            fail_q <= undervoltage_i || power_loss_i;
            fail_d <= fail_q;
        end
    end

    // Ramp tick prescaler
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tick_cnt <= 16'h0000;
            tick <= 1'b0;
        end else if (ce_i) begin
            if (tick_cnt == 16'(TICK_DIV - 1)) begin
                tick_cnt <= 16'h0000;
                tick <= 1'b1;
            end else begin
                tick_cnt <= tick_cnt + 16'h0001;
                tick <= 1'b0;
            end
        end
    end

    // Power-up start lock, released once the command is seen off
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            start_lock <= 1'b1;
        end else if (ce_i && !cmd) begin
            start_lock <= 1'b0;
        end
    end

    // Sequencer next state
    always_comb begin
        next_state = state;
        case (state)
            pfd_pkg::ST_STOP: begin
                // Loss while stopped is ignored
                if (!fail_q && !tripped_i && cmd) begin
                    if (!(start_lock && stop_select == pfd_pkg::MODE_STOP)) begin
                        next_state = pfd_pkg::ST_RUN;
                    end
                end
            end
            pfd_pkg::ST_RUN: begin
                if (tripped_i) begin
                    next_state = pfd_pkg::ST_STOP;
                end else if (fail_q) begin
                    if (stop_select == pfd_pkg::MODE_CONT) begin
                        // Command already dropped: stay on the normal ramp down
                        if (cmd) begin
                            next_state = pfd_pkg::ST_PF_DECEL;
                        end
                    end else if (auto_restart) begin
                        next_state = pfd_pkg::ST_COAST;
                    end else if (stop_select == pfd_pkg::MODE_STOP) begin
                        next_state = pfd_pkg::ST_PF_DECEL;
                    end else begin
                        next_state = pfd_pkg::ST_COAST;
                    end
                end else if (!cmd && freq_o == '0) begin
                    next_state = pfd_pkg::ST_STOP;
                end
            end
            pfd_pkg::ST_PF_DECEL: begin
                if (tripped_i) begin
                    next_state = pfd_pkg::ST_STOP;
                end else if (stop_select == pfd_pkg::MODE_CONT && !cmd) begin
                    next_state = pfd_pkg::ST_RUN;
                end else if (stop_select == pfd_pkg::MODE_CONT && !fail_q) begin
                    next_state = pfd_pkg::ST_RUN;
                end else if (freq_o == '0) begin
                    next_state = pfd_pkg::ST_PF_STOP;
                end
            end
            pfd_pkg::ST_PF_STOP: begin
                if (tripped_i) begin
                    next_state = pfd_pkg::ST_STOP;
                end else if (stop_select == pfd_pkg::MODE_CONT) begin
                    if (!fail_q) begin
                        next_state = pfd_pkg::ST_RUN;
                    end
                end else if (!fail_q && !cmd) begin
                    next_state = pfd_pkg::ST_STOP;
                end
            end
            pfd_pkg::ST_COAST: begin
                if (!fail_q) begin
                    next_state = pfd_pkg::ST_STOP;
                end
            end
            default: begin
                next_state = pfd_pkg::ST_STOP;
            end
        endcase
    end

    // State register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state <= pfd_pkg::ST_STOP;
        end else if (ce_i) begin
            state <= next_state;
        end
    end

    // Ramp target, step and forced zero per state
    always_comb begin
        ramp_target = '0;
        ramp_step = steps[pfd_pkg::PFS_LSB +: 8];
        ramp_zero = (state == pfd_pkg::ST_STOP) || (state == pfd_pkg::ST_COAST);
        if (state == pfd_pkg::ST_RUN) begin
            if (cmd) begin
                ramp_target = set_freq;
                ramp_step = steps[pfd_pkg::ACC_LSB +: 8];
            end else begin
                ramp_step = steps[pfd_pkg::DEC_LSB +: 8];
            end
        end
    end

    pfd_ramp #(
        .FREQ_W(FREQ_W)
    ) u_ramp (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .tick_i(tick),
        .zero_i(ramp_zero),
        .target_i(ramp_target),
        .step_i(ramp_step),
        .freq_o(freq_o)
    );

    // Shutoff, flag, direction and terminal outputs
    always_comb begin
        next_flag = (next_state == pfd_pkg::ST_PF_DECEL) ||
                    (next_state == pfd_pkg::ST_PF_STOP);
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            output_shutoff_o <= 1'b1;
            power_fail_decel_flag_o <= 1'b0;
            reverse_o <= 1'b0;
            term_a_o <= 1'b0;
            term_c_o <= 1'b0;
        end else if (ce_i) begin
            output_shutoff_o <= (next_state == pfd_pkg::ST_STOP) ||
                                (next_state == pfd_pkg::ST_COAST);
            power_fail_decel_flag_o <= next_flag;
            if (state == pfd_pkg::ST_STOP && next_state == pfd_pkg::ST_RUN) begin
                reverse_o <= !forward_start_cmd_i;
            end
            term_a_o <= (term_sel_a == pfd_pkg::CODE_POS && next_flag) ||
                        (term_sel_a == pfd_pkg::CODE_NEG && !next_flag);
            term_c_o <= (term_sel_c == pfd_pkg::CODE_POS && next_flag) ||
                        (term_sel_c == pfd_pkg::CODE_NEG && !next_flag);
        end
    end

    // Events for sticky status
    always_comb begin
        events = '0;
        events[pfd_pkg::EV_DECEL] = (state != pfd_pkg::ST_PF_DECEL) &&
                                    (next_state == pfd_pkg::ST_PF_DECEL);
        events[pfd_pkg::EV_PFSTOP] = (state != pfd_pkg::ST_PF_STOP) &&
                                     (next_state == pfd_pkg::ST_PF_STOP);
        events[pfd_pkg::EV_RESTORE] = fail_d && !fail_q;
        events[pfd_pkg::EV_COAST] = (state != pfd_pkg::ST_COAST) &&
                                    (next_state == pfd_pkg::ST_COAST);
        irq_clr = '0;
        if (wr && wb_adr_i == pfd_pkg::REG_IRQ_CLR) begin
            irq_clr = wb_dat_i[pfd_pkg::IRQ_W-1:0] & wmask[pfd_pkg::IRQ_W-1:0];
        end
        next_irq_stat = (irq_stat & ~irq_clr) | events;
    end

    // Sticky status and level interrupt, set wins over clear
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_stat <= '0;
            irq_o <= 1'b0;
        end else if (ce_i) begin
            irq_stat <= next_irq_stat;
            irq_o <= |(next_irq_stat & irq_en);
        end
    end

    // Software-written settings
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            stop_select <= pfd_pkg::MODE_COAST;
            restart_set <= pfd_pkg::RESTART_OFF;
            set_freq <= FREQ_W'(pfd_pkg::SETFREQ_RST);
            steps <= pfd_pkg::STEPS_RST;
            term_sel_a <= 8'h00;
            term_sel_c <= 8'h00;
            irq_en <= '0;
        end else if (wr) begin
            case (wb_adr_i)
                pfd_pkg::REG_CTRL: begin
                    stop_select <= merge(32'(stop_select), wb_dat_i, wmask)
                                   [1:0];
                end
                pfd_pkg::REG_RESTART: begin
                    restart_set <= merge(32'(restart_set), wb_dat_i, wmask)
                                   [15:0];
                end
                pfd_pkg::REG_SETFREQ: begin
                    set_freq <= merge(32'(set_freq), wb_dat_i, wmask)
                                [FREQ_W-1:0];
                end
                pfd_pkg::REG_STEPS: begin
                    steps <= merge(32'(steps), wb_dat_i, wmask)[23:0];
                end
                pfd_pkg::REG_TERM: begin
                    term_sel_a <= merge(32'(term_sel_a), wb_dat_i, wmask)
                                  [7:0];
                    term_sel_c <= merge(32'(term_sel_c) << pfd_pkg::TERMC_LSB,
                                        wb_dat_i, wmask)
                                  [pfd_pkg::TERMC_LSB +: 8];
                end
                pfd_pkg::REG_IRQ_EN: begin
                    irq_en <= merge(32'(irq_en), wb_dat_i, wmask)
                              [pfd_pkg::IRQ_W-1:0];
                end
                default: begin
                end
            endcase
        end
    end

    // Status word
    always_comb begin
        status_word = 32'(freq_o);
        status_word[pfd_pkg::ST_STATE_LSB +: 3] = state;
        status_word[pfd_pkg::ST_FLAG_BIT] = power_fail_decel_flag_o;
        status_word[pfd_pkg::ST_REV_BIT] = reverse_o;
    end

    // Bus answer one cycle after the request, unmapped reads zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else if (ce_i) begin
            wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
            wb_dat_o <= 32'h0000_0000;
            if (rd) begin
                case (wb_adr_i)
                    pfd_pkg::REG_CTRL: wb_dat_o <= 32'(stop_select);
                    pfd_pkg::REG_RESTART: wb_dat_o <= 32'(restart_set);
                    pfd_pkg::REG_SETFREQ: wb_dat_o <= 32'(set_freq);
                    pfd_pkg::REG_STEPS: wb_dat_o <= 32'(steps);
                    pfd_pkg::REG_TERM: wb_dat_o <= {16'h0000, term_sel_c, term_sel_a};
                    pfd_pkg::REG_STATUS: wb_dat_o <= status_word;
                    pfd_pkg::REG_IRQ_STAT: wb_dat_o <= 32'(irq_stat);
                    pfd_pkg::REG_IRQ_EN: wb_dat_o <= 32'(irq_en);
                    default: wb_dat_o <= 32'h0000_0000;
                endcase
            end
        end
    end

    // Checks on the sequencer and the bus answer
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    sequence run_fail_s;
        ce_i && state == pfd_pkg::ST_RUN && fail_q && !tripped_i;
    endsequence

    sequence pf_decel_s;
        ce_i && state == pfd_pkg::ST_PF_DECEL && !tripped_i;
    endsequence

    coast_shutoff_a: assert property (
        run_fail_s ##0 (stop_select == pfd_pkg::MODE_COAST)
        |=> state == pfd_pkg::ST_COAST && output_shutoff_o)
        else $error("mode 0 loss did not shut off");

    ctrl_decel_a: assert property (
        run_fail_s ##0 (stop_select == pfd_pkg::MODE_STOP && !auto_restart)
        |=> state == pfd_pkg::ST_PF_DECEL && !output_shutoff_o)
        else $error("mode 1 loss did not decelerate");

    freq_falls_a: assert property (
        pf_decel_s |=> freq_o <= $past(freq_o))
        else $error("frequency rose in loss deceleration");

    stays_stopped_a: assert property (
        ce_i && state == pfd_pkg::ST_PF_STOP && stop_select == pfd_pkg::MODE_STOP
        && cmd && !tripped_i |=> state == pfd_pkg::ST_PF_STOP)
        else $error("mode 1 stop left while command on");

    powerup_lock_a: assert property (
        ce_i && state == pfd_pkg::ST_STOP && start_lock && cmd
        && stop_select == pfd_pkg::MODE_STOP |=> state == pfd_pkg::ST_STOP)
        else $error("start taken with power-up lock");

    reaccel_a: assert property (
        pf_decel_s ##0 (stop_select == pfd_pkg::MODE_CONT && !fail_q && cmd)
        |=> state == pfd_pkg::ST_RUN && ramp_target == set_freq)
        else $error("mode 2 did not reaccelerate");

    auto_coast_a: assert property (
        run_fail_s ##0 (auto_restart && stop_select == pfd_pkg::MODE_STOP)
        |=> state == pfd_pkg::ST_COAST)
        else $error("auto restart did not override stop");

    flag_state_a: assert property (
        power_fail_decel_flag_o == (state == pfd_pkg::ST_PF_DECEL ||
                                    state == pfd_pkg::ST_PF_STOP))
        else $error("flag disagrees with state");

    term_pol_a: assert property (
        ce_i && term_sel_a == pfd_pkg::CODE_NEG && $stable(term_sel_a)
        |=> term_a_o == !power_fail_decel_flag_o)
        else $error("inverted terminal wrong");

    stopped_ignore_a: assert property (
        ce_i && state == pfd_pkg::ST_STOP && fail_q |=> state == pfd_pkg::ST_STOP)
        else $error("loss acted while stopped");

    bus_ack_a: assert property (
        ce_i && wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
        else $error("ack not a single cycle");
endmodule
`default_nettype wire

// ---- verif/pfd_supply.sv ----
// Supply monitor model reporting loss on either detection line
`timescale 1ns/1ps
`default_nettype none
module pfd_supply (
    input wire logic clk_i,
    input wire logic [1:0] fail_i,
    output logic undervoltage_o,
    output logic power_loss_o
);
    // Detections change only just after an edge, two separate lines
    always_ff @(posedge clk_i) begin
        undervoltage_o <= fail_i[0];
        power_loss_o <= fail_i[1];
    end
endmodule
`default_nettype wire

// ---- verif/power_fail_decel_control_test.sv ----
// Self-checking bench for the power-fail deceleration controller
`timescale 1ns/1ps
`default_nettype none
module power_fail_decel_control_test;
    logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, fwd = 1, rev = 0, trip = 1, ce = 1;
    logic [7:0] adr = 8'h00;
    logic [31:0] dat = 32'h0000_0000, q, rd;
    logic [1:0] fail = 2'h0;
    logic uv, pl, ack, shut, revo, flag, ta, tc, irq;
    logic [15:0] freq;
    int fails = 0, tests_run = 0, cycles = 0;
    pfd_supply SUP (.clk_i(clk_i), .fail_i(fail), .undervoltage_o(uv), .power_loss_o(pl));
    pfd_ctrl #(.FREQ_W(16), .TICK_DIV(2)) DUT (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
        .wb_dat_i(dat), .wb_dat_o(rd), .wb_ack_o(ack), .undervoltage_i(uv),
        .power_loss_i(pl), .forward_start_cmd_i(fwd), .reverse_start_cmd_i(rev),
        .tripped_i(trip), .output_shutoff_o(shut), .freq_o(freq), .reverse_o(revo),
        .power_fail_decel_flag_o(flag), .term_a_o(ta), .term_c_o(tc), .irq_o(irq));
    // Clock and hang guard
    always #2 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles > 20000) begin
            fails++;
            wrap_up();
        end
    end
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic w(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    // One classic single cycle, held until ack is sampled high
    task automatic wb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        cyc <= 1; stb <= 1; we <= wr; adr <= a; dat <= d;
        @(posedge clk_i);
        while (ack !== 1'b1) @(posedge clk_i);
        q = rd;
        cyc <= 0; stb <= 0; we <= 0;
        @(posedge clk_i);
    endtask
    task automatic st(input logic [3:0] e);
        wb(0, pfd_pkg::REG_STATUS, 32'h0000_0000);
        chk({28'h000_0000, q[19:16]}, {28'h000_0000, e});
    endtask
    task automatic t_regs();
        wb(0, pfd_pkg::REG_CTRL, 0); chk(q, 32'h0000_0000);
        wb(0, pfd_pkg::REG_RESTART, 0); chk(q, 32'h0000_270f);
        wb(0, pfd_pkg::REG_STEPS, 0); chk(q, 32'h0001_0101);
        wb(1, 8'h40, 32'hffff_ffff); wb(0, 8'h40, 0); chk(q, 32'h0000_0000);
        wb(1, pfd_pkg::REG_TERM, 32'h0000_922e);
        wb(1, pfd_pkg::REG_SETFREQ, 32'h0000_0008);
        wb(1, pfd_pkg::REG_IRQ_EN, 32'h0000_0001);
    endtask
    // Start command held since power-up keeps the drive stopped in mode 1 until it is cycled off
    task automatic t_lock();
        wb(1, pfd_pkg::REG_CTRL, 1); trip <= 0; w(30);
        chk(shut, 1); st(4'h0);
        fwd <= 0; w(4); fwd <= 1; w(30);
        chk(shut, 0); chk(freq, 8);
    endtask
    task automatic t_mode1();
        fail <= 2'h2; w(8);
        chk(flag, 1); chk(shut, 0); chk(freq < 8, 1);
        chk(ta, 1); chk(tc, 0); chk(irq, 1);
        fail <= 2'h0; w(30);
        st(4'hb); chk(freq, 0); chk(tc, 0);
        wb(0, pfd_pkg::REG_IRQ_STAT, 0); chk(q, 32'h0000_0007);
        wb(1, pfd_pkg::REG_IRQ_CLR, 32'h0000_000f); chk(irq, 0);
        wb(0, pfd_pkg::REG_IRQ_STAT, 0); chk(q, 32'h0000_0000);
        fwd <= 0; w(5); chk(flag, 0); chk(shut, 1); chk(tc, 1);
        fwd <= 1; w(30); chk(freq, 8);
    endtask
    task automatic t_mode0();
        wb(1, pfd_pkg::REG_CTRL, 0);
        fail <= 2'h1; w(5);
        chk(shut, 1); chk(freq, 0); st(4'h4);
        fail <= 2'h0; w(30); chk(freq, 8);
    endtask
    task automatic t_mode2(input logic [15:0] rs, input logic keep);
        wb(1, pfd_pkg::REG_RESTART, {16'h0000, rs});
        wb(1, pfd_pkg::REG_CTRL, 2);
        fail <= 2'h1; w(6);
        chk(shut, 0); chk(flag, 1);
        fwd <= keep; w(2); fail <= 2'h0; w(30);
        chk(freq, keep ? 8 : 0); chk(flag, 0);
        fwd <= 1; w(30);
    endtask
    task automatic t_auto();
        wb(1, pfd_pkg::REG_RESTART, 0);
        wb(1, pfd_pkg::REG_CTRL, 1);
        fail <= 2'h2; w(5);
        st(4'h4); chk(shut, 1);
        fail <= 2'h0; w(30);
        t_mode2(16'h0000, 1);
        wb(1, pfd_pkg::REG_RESTART, 32'h0000_270f);
    endtask
    task automatic t_idle();
        logic [15:0] h;
        wb(1, pfd_pkg::REG_CTRL, 1);
        // Clock enable low freezes the ramp mid-way
        fwd <= 0; w(6); ce <= 0; w(1); h = freq;
        w(10); chk(freq, h); chk(h != 0, 1);
        ce <= 1; w(30); st(4'h0);
        fail <= 2'h3; w(6); st(4'h0);
        fail <= 2'h0; fwd <= 1; w(30);
        trip <= 1; w(5); fail <= 2'h2; w(6);
        st(4'h0); chk(flag, 0);
        // Reverse start alone latches reverse direction
        fail <= 2'h0; trip <= 0; fwd <= 0; rev <= 1; w(6);
        chk(revo, 1); chk(shut, 0);
    endtask
    // Main sequence
    initial begin
        w(2);
        rst_i <= 0;
        t_regs();
        t_lock();
        t_mode1();
        t_mode0();
        t_mode2(16'h270f, 1);
        t_mode2(16'h270f, 0);
        t_auto();
        t_idle();
        wrap_up();
    end
endmodule
`default_nettype wire
